/* File: tb_tpi_irq_ctrl.sv */
/*
  Self-checking bench for the interrupt request block: register port,
  timer and pin events, vectoring. Assumes the core stand-in model.
*/
module tb_tpi_irq_ctrl import tpi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic              mclk      = 1'b0;
  logic              rst_n     = 1'b0;
  tpi_bus_req_t      bus       = '0;
  logic              timerAOvf = 1'b0;
  logic              timerBOvf = 1'b0;
  logic              pinAIn    = 1'b0;
  logic              pinBIn    = 1'b0;
  logic              slowMode  = 1'b1;
  logic              retiDone, vectorTake, stackPush, irqPending;
  logic [DATA_W-1:0] rdData, m;
  logic [PC_W-1:0]   vectorPc;
  int                error_cnt, cmp_count, takeCnt, t0, s, b, k;
  logic              en, g;
  localparam int     RTC_WAIT = 3200; // Timer A clear delay, 16 us

  tpi_irq_ctrl DUT (.mclk(mclk), .rst_n(rst_n), .bus(bus),
    .rdData(rdData), .timerAOvf(timerAOvf), .timerBOvf(timerBOvf),
    .pinAIn(pinAIn), .pinBIn(pinBIn), .retiDone(retiDone),
    .vectorTake(vectorTake), .vectorPc(vectorPc),
    .stackPush(stackPush), .irqPending(irqPending));

  tpi_core_model core (.mclk(mclk), .rst_n(rst_n),
    .vectorTake(vectorTake), .slowMode(slowMode), .retiDone(retiDone));

  // Clock at 200 MHz
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [11:0] sv, ev);
    cmp_count++;
    if (sv !== ev) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, ev, sv);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask

  task automatic rdChk(input string nm, input logic [7:0] a, e);
    @(posedge mclk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 chk(nm, 12'(rdData), 12'(e));
  endtask

  // Overflow pulse only; the service side never reloads a count
  task automatic ovf(input int sel);
    @(posedge mclk);
    if (sel == 0) timerAOvf <= 1'b1;
    else timerBOvf <= 1'b1;
    @(posedge mclk);
    timerAOvf <= 1'b0;
    timerBOvf <= 1'b0;
  endtask

  // Every take must load the vector and push the stack
  always @(posedge mclk) begin
    if (vectorTake === 1'b1) begin
      takeCnt++;
      chk("vectorPc", vectorPc, VECTOR_ADDR);
      chk("stackPush", 12'(stackPush), 12'h001);
    end
  end

  // Cuts a hang short
  initial begin
    #450000;
    error_cnt++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [7:0] ra[5] = '{OFS_REQ, OFS_EN, OFS_GIE, OFS_EDGE, 8'hC0};
    logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
    logic [7:0] rf[5] = '{SRC_MASK, SRC_MASK, 8'h80, 8'h18, 8'h00};
    void'($urandom(71711));
    ticks(3);
    rst_n <= 1'b1;
    ticks(4);
    for (int i = 0; i < 5; i++) rdChk("rst", ra[i], rv[i]);
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], 8'hFF);
      rdChk("acc", ra[i], rf[i]);
    end
    wr(OFS_REQ, 8'h00);
    wr(OFS_EN, 8'h00);
    wr(OFS_GIE, 8'h00);
    rdChk("clr", OFS_REQ, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      s = $urandom % 2;
      en = 1'($urandom % 2);
      g = 1'($urandom % 2);
      b = (s == 1) ? BIT_TB : BIT_TA;
      m = 8'h01 << b;
      wr(OFS_EN, en ? m : 8'h00);
      wr(OFS_GIE, {g, 7'h00});
      t0 = takeCnt;
      ovf(s);
      ticks(4);
      rdChk("flag", OFS_REQ, m);
      chk("take", 12'(takeCnt - t0), 12'(en & g));
      chk("pend", 12'(irqPending), 12'(en & g));
      if (s == 0) ticks(RTC_WAIT);
      wr(OFS_REQ, 8'h00);
      wr(OFS_GIE, 8'h00);
      ticks(22);
    end
    $display("test timer events done");
    slowMode <= 1'b0;
    wr(OFS_EN, 8'h40);
    wr(OFS_GIE, 8'h80);
    t0 = takeCnt;
    ovf(1);
    k = 0;
    while (takeCnt == t0 && k < 10) begin
      @(posedge mclk);
      k++;
    end
    if (k == 10) begin
      error_cnt++;
      close_out();
    end
    ticks(10);
    chk("retake", 12'(takeCnt - t0 >= 2), 12'h001);
    chk("pending", 12'(irqPending), 12'h001);
    wr(OFS_GIE, 8'h00);
    wr(OFS_REQ, 8'h00);
    wr(OFS_EN, 8'h00);
    slowMode <= 1'b1;
    ticks(25);
    $display("test vectoring done");
    @(posedge mclk);
    bus <= '{OFS_REQ, 8'h00, 1'b1, 1'b0};
    timerAOvf <= 1'b1;
    @(posedge mclk);
    bus <= '0;
    timerAOvf <= 1'b0;
    rdChk("setWins", OFS_REQ, 8'h10);
    $display("test set against clear done");
    for (int c = 0; c < 4; c++) begin
      wr(OFS_EDGE, {3'h0, c[1:0], 3'h0});
      wr(OFS_REQ, 8'h00);
      pinAIn <= 1'b1;
      ticks(5);
      rdChk("pinRise", OFS_REQ, {7'h00, c[0]});
      wr(OFS_REQ, 8'h00);
      pinAIn <= 1'b0;
      ticks(5);
      rdChk("pinFall", OFS_REQ, {7'h00, c[1]});
    end
    wr(OFS_REQ, 8'h00);
    pinBIn <= 1'b1;
    ticks(5);
    rdChk("pinBRise", OFS_REQ, 8'h00);
    pinBIn <= 1'b0;
    ticks(5);
    rdChk("pinBFall", OFS_REQ, 8'h02);
    $display("test pin edges done");
    close_out();
  end
endmodule // tb_tpi_irq_ctrl

/* File: tpi_core_model.sv */
/*
  Processor core stand-in for the interrupt block: takes the vector
  and ends service with a one-cycle pulse. Assumes the same clock
  and reset as the block under test.
*/
module tpi_core_model (
  input  wire logic mclk,       // System clock
  input  wire logic rst_n,      // Async reset, low
  input  wire logic vectorTake, // Divert pulse from block
  input  wire logic slowMode,   // Long service when high
  output logic      retiDone    // End of service pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] svcCnt;

  // Runs the service routine for a short or long time, then returns
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      svcCnt   <= 5'h00;
      retiDone <= 1'b0;
    end else begin
      retiDone <= 1'b0;
      if (vectorTake) begin
        svcCnt <= slowMode ? 5'h14 : 5'h03;
      end else if (svcCnt == 5'h01) begin
        svcCnt   <= 5'h00;
        retiDone <= 1'b1;
      end else if (svcCnt != 5'h00) begin
        svcCnt <= svcCnt - 5'h01;
      end
    end
  end
endmodule // tpi_core_model

/* File: tpi_irq_ctrl.sv */
/*
  Interrupt request and enable logic for two timer overflows and two
  external pins, with one shared vector. Assumes timer overflow
  pulses come from logic on mclk, pins are asynchronous, and the core
  reports the end of service with a one-cycle pulse.
*/
// Chosen here: the register addresses and the address-and-strobe port.
module tpi_irq_ctrl
  import tpi_pkg::*;
(
  input  wire logic              mclk,       // 200 MHz clock
  input  wire logic              rst_n,      // Async reset, low
  input  wire tpi_bus_req_t      bus,        // Register port request
  output logic [DATA_W-1:0]      rdData,     // Read data, next cycle
  input  wire logic              timerAOvf,  // Timer A overflow pulse
  input  wire logic              timerBOvf,  // Timer B overflow pulse
  input  wire logic              pinAIn,     // Pin A, asynchronous
  input  wire logic              pinBIn,     // Pin B, asynchronous
  input  wire logic              retiDone,   // Core left service
  output logic                   vectorTake, // Divert pulse to core
  output logic [PC_W-1:0]        vectorPc,   // Program counter load
  output logic                   stackPush,  // Push return address
  output logic                   irqPending  // Enabled request level
);

  // Address match, used by every decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Edge match for the pin A select field
  function automatic logic edgeHit(input logic [1:0] sel,
                                   input logic       rise,
                                   input logic       fall);
    case (sel)
      EDGE_RISE: edgeHit = rise;
      EDGE_FALL: edgeHit = fall;
      EDGE_BOTH: edgeHit = rise | fall;
      default:   edgeHit = 1'b0;
    endcase
  endfunction

  logic              rstMeta;
  logic              rstSyncN;
  logic [1:0]        pinAMeta;
  logic [1:0]        pinBMeta;
  logic              pinASync;
  logic              pinBSync;
  logic              pinALast;
  logic              pinBLast;
  logic              riseA;
  logic              fallA;
  logic              fallB;
  logic [DATA_W-1:0] evVec;
  logic [DATA_W-1:0] reqReg;
  logic [DATA_W-1:0] reqNext;
  logic [DATA_W-1:0] enReg;
  logic              gieReg;
  logic [1:0]        edgeReg;
  logic              inSvcReg;
  logic              armed;
  logic              firing;
  logic              wrReq;
  logic              wrEn;
  logic              wrGie;
  logic              wrEdge;

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta  <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinAMeta <= 2'h0;
      pinBMeta <= 2'h0;
    end else begin
      pinAMeta <= {pinAMeta[0], pinAIn};
      pinBMeta <= {pinBMeta[0], pinBIn};
    end
  end

  assign pinASync = pinAMeta[1];
  assign pinBSync = pinBMeta[1];

  // Previous synchronised level for edge detection
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinALast <= 1'b0;
      pinBLast <= 1'b0;
    end else begin
      pinALast <= pinASync;
      pinBLast <= pinBSync;
    end
  end

  // Edge detection on synchronised pins
  assign riseA = pinASync & ~pinALast;
  assign fallA = ~pinASync & pinALast;
  assign fallB = ~pinBSync & pinBLast;

  // Trigger events in request register layout
  always_comb begin
    evVec          = DATA_ZERO;
    evVec[BIT_PA]  = edgeHit(edgeReg, riseA, fallA);
    evVec[BIT_PB]  = fallB;
    evVec[BIT_TA]  = timerAOvf;
    evVec[BIT_TB]  = timerBOvf;
  end

  // Write decode
  assign wrReq  = bus.wr & hit(bus.addr, OFS_REQ);
  assign wrEn   = bus.wr & hit(bus.addr, OFS_EN);
  assign wrGie  = bus.wr & hit(bus.addr, OFS_GIE);
  assign wrEdge = bus.wr & hit(bus.addr, OFS_EDGE);

  // Flag update: event wins over a software clear
  always_comb begin
    if (wrReq) begin
      reqNext = (bus.wdata & SRC_MASK) | evVec;
    end else begin
      reqNext = reqReg | evVec;
    end
  end

  // Request flags, never cleared by vectoring
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      reqReg <= DATA_ZERO;
    end else begin
      reqReg <= reqNext;
    end
  end

  // Source enables
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      enReg <= DATA_ZERO;
    end else if (wrEn) begin
      enReg <= bus.wdata & SRC_MASK;
    end
  end

  // Global enable, cleared by reset
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      gieReg <= 1'b0;
    end else if (wrGie) begin
      gieReg <= bus.wdata[BIT_GIE];
    end
  end

  // Pin A edge select
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      edgeReg <= EDGE_RST;
    end else if (wrEdge) begin
      edgeReg <= bus.wdata[EDGE_HI:EDGE_LO];
    end
  end

  // Diversion needs a flag, its enable and the global enable
  assign armed  = (|(reqReg & enReg)) & gieReg;
  assign firing = armed & ~inSvcReg;

  // Service state keeps one take per entry
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      inSvcReg <= 1'b0;
    end else if (firing) begin
      inSvcReg <= 1'b1;
    end else if (retiDone) begin
      inSvcReg <= 1'b0;
    end
  end

  // Vector take, program counter load and stack push
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      vectorTake <= 1'b0;
      stackPush  <= 1'b0;
      vectorPc   <= PC_ZERO;
    end else begin
      vectorTake <= firing;
      stackPush  <= firing;
      if (firing) begin
        vectorPc <= VECTOR_ADDR;
      end
    end
  end

  // Pending level for the core
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      irqPending <= 1'b0;
    end else begin
      irqPending <= armed;
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rdData <= DATA_ZERO;
    end else if (!bus.rd) begin
      rdData <= DATA_ZERO;
    end else if (hit(bus.addr, OFS_REQ)) begin
      rdData <= reqReg;
    end else if (hit(bus.addr, OFS_EN)) begin
      rdData <= enReg;
    end else if (hit(bus.addr, OFS_GIE)) begin
      rdData <= {gieReg, 7'h00};
    end else if (hit(bus.addr, OFS_EDGE)) begin
      rdData <= {3'h0, edgeReg, 3'h0};
    end else begin
      rdData <= DATA_ZERO;
    end
  end

  // Timer A overflow always lands in its flag
  property p_ta_flag;
    @(posedge mclk) disable iff (!rstSyncN)
    timerAOvf |=> reqReg[BIT_TA];
  endproperty
  a_ta_flag: assert property (p_ta_flag)
    else $error("timer A overflow did not set its flag");

  // Enabled timer A request leads to one take
  sequence s_ta_armed;
    reqReg[BIT_TA] && enReg[BIT_TA] && gieReg && !inSvcReg;
  endsequence
  property p_ta_vec;
    @(posedge mclk) disable iff (!rstSyncN)
    s_ta_armed |=> vectorTake ##1 !vectorTake;
  endproperty
  a_ta_vec: assert property (p_ta_vec)
    else $error("enabled timer A request was not taken once");

  // Disabled timer A alone never diverts
  property p_ta_novec;
    @(posedge mclk) disable iff (!rstSyncN)
    (reqReg[BIT_TA] && !enReg[BIT_TA] && (reqReg & enReg) == DATA_ZERO)
      |=> !vectorTake;
  endproperty
  a_ta_novec: assert property (p_ta_novec)
    else $error("disabled timer A request diverted execution");

  // Timer B overflow always lands in its flag
  property p_tb_flag;
    @(posedge mclk) disable iff (!rstSyncN)
    timerBOvf |=> reqReg[BIT_TB];
  endproperty
  a_tb_flag: assert property (p_tb_flag)
    else $error("timer B overflow did not set its flag");

  // Enabled timer B overflow reaches the vector two to three cycles later
  sequence s_tb_event;
    timerBOvf && enReg[BIT_TB] && gieReg && !inSvcReg && !retiDone
      && !firing;
  endsequence
  property p_tb_vec;
    @(posedge mclk) disable iff (!rstSyncN)
    s_tb_event ##1 (enReg[BIT_TB] && gieReg) |-> ##[1:2] vectorTake;
  endproperty
  a_tb_vec: assert property (p_tb_vec)
    else $error("enabled timer B overflow was not taken");

  // Disabled timer B alone never diverts
  property p_tb_novec;
    @(posedge mclk) disable iff (!rstSyncN)
    (reqReg[BIT_TB] && !enReg[BIT_TB] && (reqReg & enReg) == DATA_ZERO)
      |=> !vectorTake;
  endproperty
  a_tb_novec: assert property (p_tb_novec)
    else $error("disabled timer B request diverted execution");

  // Each take comes from an enabled flag under the global enable
  property p_take_cause;
    @(posedge mclk) disable iff (!rstSyncN)
    vectorTake |-> $past(armed) && !$past(inSvcReg);
  endproperty
  a_take_cause: assert property (p_take_cause)
    else $error("take without enabled flag and global enable");

  // Pin A rising edge sets the flag when rising is selected
  property p_pa_rise;
    @(posedge mclk) disable iff (!rstSyncN)
    $rose(pinASync) && edgeReg == EDGE_RISE |=> reqReg[BIT_PA];
  endproperty
  a_pa_rise: assert property (p_pa_rise)
    else $error("pin A rising edge missed its flag");

  // Pin A rising edge ignored when falling is selected
  property p_pa_sel;
    @(posedge mclk) disable iff (!rstSyncN)
    !reqReg[BIT_PA] && $rose(pinASync) && edgeReg == EDGE_FALL
      && !wrReq |=> !reqReg[BIT_PA];
  endproperty
  a_pa_sel: assert property (p_pa_sel)
    else $error("pin A flag set on an unselected edge");

  // Pin B flag rises only after a falling pin or a write
  property p_pb_fall;
    @(posedge mclk) disable iff (!rstSyncN)
    $rose(reqReg[BIT_PB]) |-> $past(fallB) || $past(wrReq);
  endproperty
  a_pb_fall: assert property (p_pb_fall)
    else $error("pin B flag set without a falling edge");

  // Program counter carries the shared vector on a take
  property p_vec_addr;
    @(posedge mclk) disable iff (!rstSyncN)
    vectorTake |-> vectorPc == VECTOR_ADDR;
  endproperty
  a_vec_addr: assert property (p_vec_addr)
    else $error("take without the shared vector address");

  // No take once the global enable has been off for two cycles
  property p_gie_off;
    @(posedge mclk) disable iff (!rstSyncN)
    !gieReg [*2] |=> !vectorTake;
  endproperty
  a_gie_off: assert property (p_gie_off)
    else $error("take while the global enable was off");

  // Flag stays set across a take unless software writes it
  property p_no_autoclr;
    @(posedge mclk) disable iff (!rstSyncN)
    vectorTake && reqReg[BIT_TA] && !$past(wrReq) && !wrReq
      |=> reqReg[BIT_TA];
  endproperty
  a_no_autoclr: assert property (p_no_autoclr)
    else $error("flag cleared by vectoring");

  // Every take pushes exactly one level
  property p_push;
    @(posedge mclk) disable iff (!rstSyncN)
    vectorTake == stackPush;
  endproperty
  a_push: assert property (p_push)
    else $error("take and stack push disagree");

  // Overflow beside a clear of the same flag keeps it set
  property p_set_wins;
    @(posedge mclk) disable iff (!rstSyncN)
    wrReq && !bus.wdata[BIT_TA] && timerAOvf |=> reqReg[BIT_TA];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a same-cycle overflow");

endmodule // tpi_irq_ctrl

/* File: tpi_pkg.sv */
/*
  Constants, register map and bus carrier for the timer and pin
  interrupt request block. Assumes an 8-bit register port and a
  processor core on the same clock that takes the vector.
*/
package tpi_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PC_W   = 12;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_REQ  = 8'hC8;
  localparam logic [ADDR_W-1:0] OFS_EN   = 8'hC9;
  localparam logic [ADDR_W-1:0] OFS_GIE  = 8'hDF;
  localparam logic [ADDR_W-1:0] OFS_EDGE = 8'hBF;

  // Bit positions shared by request and enable registers, then the global enable bit and edge select field
  localparam int BIT_PA  = 0;
  localparam int BIT_PB  = 1;
  localparam int BIT_TA  = 4;
  localparam int BIT_TB  = 6;
  localparam int BIT_GIE = 7;
  localparam int EDGE_LO = 3;
  localparam int EDGE_HI = 4;

  // Implemented bits of the request and enable registers
  localparam logic [DATA_W-1:0] SRC_MASK  = 8'h53;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // Pin A edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] EDGE_RST  = EDGE_FALL;

  // Shared interrupt vector
  localparam logic [PC_W-1:0] VECTOR_ADDR = 12'h008;
  localparam logic [PC_W-1:0] PC_ZERO     = 12'h000;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tpi_bus_req_t;

endpackage
